// ==== dac_code_path_slew_clear.sv ====
// converter code path: calibration, digital slew and clear state behind an AHB-Lite slave
// Behaviour
// (RULE1) output code limited to 0 through 2^N-1
// (RULE2) range from fallback span bit while clearing
// (RULE3) software rewrites data after changing trims
// (RULE4) gain factor is half plus gain/2^N
// (RULE5) gain left justified, low bits ignored narrow
// (RULE6) offset is left-justified two's complement
// (RULE7) code equals data times gain plus offset
// (RULE8) multiplier product truncated, never rounded
// (RULE9) data left justified, low bits ignored narrow
// (RULE10) slew off after reset, enable bit
// (RULE11) stepped slew: step field and rate field
// (RULE12) clear state slews toward clear code
// (RULE13) data write slews from present code
// (RULE14) update rate independent of output range
// (RULE15) linear slew default, sinusoidal selectable
// (RULE16) slew disable mid-slew jumps to target
// (RULE17) clear drives clear code and fallback range
// (RULE18) clear from command bit, alarm or pin
// (RULE19) alarm clear gated by action and masks
// (RULE20) clear pin or serial input by mode
// (RULE21) supply fault raises alarm, applies action
// (RULE22) leaving clear returns to data code
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
module dac_code_path_slew_clear
	import dac_code_pkg::*;
#(
	parameter bit LOW_RES = 1'b0
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	output logic [31:0] HRDATA_O,
	input wire logic FALLBACK_INPUT_PIN_I,
	input wire logic BREAK_SDI_I,
	input wire logic BREAK_MODE_LINK_I,
	input wire logic [FAULT_W-1:0] FAULT_EVENTS_I,
	output logic [CODE_W-1:0] DAC_CODE_O,
	output logic RANGE_SEL_O,
	output logic CLEAR_STATE_O,
	output logic SLEWING_O
);

	// bus address phase capture
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rdata_q;
	// registers
	logic [15:0] data_q;
	logic [15:0] gain_q;
	logic [15:0] offset_q;
	logic [15:0] fb_code_q;
	logic [10:0] cfg_q;
	logic [15:0] fault_resp_q;
	// code path state
	logic cal_load_q;
	logic [15:0] cal_target_q;
	logic [15:0] code_q;
	logic [15:0] last_target_q;
	logic [15:0] start_q;
	logic [11:0] tick_cnt_q;
	logic range_q;
	logic clear_q;
	slew_state_e state_q;

	// ---- bus decode ----
	wire logic addr_valid = HSEL_I & HREADY_I & HTRANS_I[1];
	wire logic wr_take = addr_valid & HWRITE_I;
	wire logic rd_take = addr_valid & ~HWRITE_I;
	wire logic [7:0] rd_addr = HADDR_I[7:0];
	wire logic [7:0] in_range = {HADDR_I[31:8] == 24'h000000, 7'h00} >> 7;
	wire logic wr_data = wr_pend_q & (wr_addr_q == DATA_OFS);
	wire logic wr_gain = wr_pend_q & (wr_addr_q == GAIN_OFS);
	wire logic wr_offset = wr_pend_q & (wr_addr_q == OFFSET_OFS);
	wire logic wr_fb_code = wr_pend_q & (wr_addr_q == CLR_CODE_OFS);
	wire logic wr_cfg = wr_pend_q & (wr_addr_q == CFG_OFS);
	wire logic wr_fault_resp = wr_pend_q & (wr_addr_q == FAULT_RESP_OFS);

	// ---- configuration fields ----
	wire logic slew_enable = cfg_q[CFG_SLEW_EN];
	wire logic [2:0] slew_step_size = cfg_q[CFG_STEP_LO +: 3];
	wire logic [2:0] slew_update_rate = cfg_q[CFG_RATE_LO +: 3];
	wire logic slew_profile_select = cfg_q[CFG_PROFILE];
	wire logic span_select = cfg_q[CFG_RANGE];
	wire logic fallback_span_select = cfg_q[CFG_FB_SPAN];
	wire logic force_fallback_cmd = cfg_q[CFG_FORCE_FB];
	wire logic [1:0] fault_act_raw = fault_resp_q[RESP_ACT_LO +: 2];
	wire logic [FAULT_W-1:0] fault_mask = fault_resp_q[RESP_MASK_LO +: FAULT_W];

	// ---- alarm gating, one term per fault condition ----
	logic [FAULT_W-1:0] fault_live;
	genvar gi;
	generate
		for (gi = 0; gi < FAULT_W; gi++) begin : g_fault
			// a masked condition never reaches the action logic
			assign fault_live[gi] = FAULT_EVENTS_I[gi] & ~fault_mask[gi]; // see (RULE19)
		end
	endgenerate
	// supply-window fault sits on its own bit and follows the same action path
	wire logic supply_alarm = fault_live[SUPPLY_FAULT_BIT]; // see (RULE21)
	wire logic alarm_any = (|fault_live) | supply_alarm;
	wire logic alarm_clear = alarm_any & (fault_act_raw == ACT_CLEAR); // see (RULE19) (RULE21)

	// ---- clear sources ----
	// in break mode the dedicated pin is tied low outside, the serial input carries clear
	wire logic pin_clear = BREAK_MODE_LINK_I ? BREAK_SDI_I : FALLBACK_INPUT_PIN_I; // see (RULE20)
	wire logic clear_active = force_fallback_cmd | alarm_clear | pin_clear; // see (RULE18)

	// ---- calibration ----
	wire logic [15:0] res_mask = LOW_RES ? LOW_RES_MASK : FULL_RES_MASK;
	wire logic [15:0] data_eff = data_q & res_mask; // see (RULE9)
	wire logic [15:0] gain_eff = gain_q & res_mask; // see (RULE5)
	wire logic [15:0] offset_eff = offset_q & res_mask; // see (RULE6)
	// factor scaled by 2^16: one half is 0x8000, gain adds directly
	wire logic [16:0] gain_factor = GAIN_HALF + {1'b0, gain_eff}; // see (RULE4)
	wire logic [32:0] cal_product = data_eff * gain_factor;
	// low sixteen bits dropped, no rounding term added
	wire logic [16:0] cal_scaled = cal_product[32:16]; // see (RULE8)
	wire logic signed [18:0] cal_sum = $signed({2'b00, cal_scaled})
		+ $signed({{3{offset_eff[15]}}, offset_eff}); // see (RULE7) (RULE6)
	logic [15:0] cal_code;
	always_comb begin
		// saturate so the code never wraps between the rails
		if (cal_sum < 0) begin
			cal_code = 16'h0000; // see (RULE1)
		end else if (cal_sum > $signed(CODE_MAX)) begin
			cal_code = 16'hFFFF & res_mask; // see (RULE1)
		end else begin
			cal_code = cal_sum[15:0] & res_mask;
		end
	end

	// ---- target selection ----
	wire logic [15:0] fb_code_eff = fb_code_q & res_mask;
	// leaving clear falls back to the last calibrated data target
	wire logic [15:0] target = clear_active ? fb_code_eff : cal_target_q; // see (RULE17) (RULE22)
	wire logic retarget = target != last_target_q;

	// ---- slew tick divider, same periods for every range ----
	wire logic [11:0] period_cycles = 12'(SLEW_PERIOD_NS[slew_update_rate] / CLK_PERIOD_NS); // see (RULE14)
	wire logic tick = tick_cnt_q >= (period_cycles - 12'h001); // see (RULE11)

	// ---- step computation ----
	wire logic [15:0] base_step = SLEW_STEP_LSB[slew_step_size]; // see (RULE11)
	wire logic going_up = target > code_q;
	wire logic [15:0] remaining = going_up ? (target - code_q) : (code_q - target);
	wire logic [15:0] travelled = (code_q > start_q) ? (code_q - start_q) : (start_q - code_q);
	wire logic [15:0] span_total = travelled + remaining;
	wire logic [15:0] edge_len = span_total >> SIN_EDGE_SHIFT;
	// sinusoidal: slow near both ends, faster through the middle half
	wire logic in_edge = (travelled < edge_len) | (remaining < edge_len);
	wire logic [16:0] boosted = {1'b0, base_step} << SIN_BOOST_SHIFT;
	wire logic [16:0] step_wide = (slew_profile_select & ~in_edge) ? boosted
		: {1'b0, base_step}; // see (RULE15)
	wire logic overshoot = step_wide >= {1'b0, remaining};
	wire logic [15:0] step_val = step_wide[15:0];
	wire logic [15:0] next_code = overshoot ? target
		: (going_up ? (code_q + step_val) : (code_q - step_val));

	// ---- read mux ----
	wire logic [31:0] status_word = {14'h0000, state_q == SLEW_RUN, clear_q, code_q};
	logic [31:0] rd_mux;
	always_comb begin
		unique case (rd_addr)
			DATA_OFS: rd_mux = {16'h0000, data_q};
			GAIN_OFS: rd_mux = {16'h0000, gain_q};
			OFFSET_OFS: rd_mux = {16'h0000, offset_q};
			CLR_CODE_OFS: rd_mux = {16'h0000, fb_code_q};
			CFG_OFS: rd_mux = {21'h000000, cfg_q};
			FAULT_RESP_OFS: rd_mux = {16'h0000, fault_resp_q};
			STATUS_OFS: rd_mux = status_word;
			default: rd_mux = 32'h00000000;
		endcase
	end

	// ---- bus slave: zero wait states, always OKAY ----
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else begin
			wr_pend_q <= wr_take & in_range[0];
			wr_addr_q <= rd_addr;
			if (rd_take) begin
				rdata_q <= in_range[0] ? rd_mux : 32'h00000000;
			end
		end
	end

	// ---- register writes ----
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			data_q <= DATA_RST;
			gain_q <= GAIN_RST;
			offset_q <= OFFSET_RST;
			fb_code_q <= CLR_CODE_RST;
			cfg_q <= CFG_RST; // see (RULE10) (RULE15)
			fault_resp_q <= FAULT_RESP_RST;
		end else begin
			if (wr_data) begin
				data_q <= HWDATA_I[15:0];
			end
			if (wr_gain) begin
				gain_q <= HWDATA_I[15:0];
			end
			if (wr_offset) begin
				offset_q <= HWDATA_I[15:0];
			end
			if (wr_fb_code) begin
				fb_code_q <= HWDATA_I[15:0];
			end
			if (wr_cfg) begin
				cfg_q <= HWDATA_I[10:0];
			end
			if (wr_fault_resp) begin
				fault_resp_q <= HWDATA_I[15:0];
			end
		end
	end

	// ---- calibrated target latched only after a data write ----
	// trims written alone do not move the output until data is rewritten
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			cal_load_q <= 1'b0;
			cal_target_q <= 16'h0000;
		end else begin
			cal_load_q <= wr_data;
			if (cal_load_q) begin
				cal_target_q <= cal_code; // see (RULE3) (RULE7)
			end
		end
	end

	// ---- tick divider ----
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			tick_cnt_q <= 12'h000;
		end else if (retarget | tick | (state_q == SLEW_IDLE)) begin
			tick_cnt_q <= 12'h000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 12'h001;
		end
	end

	// ---- code update and slew state ----
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			state_q <= SLEW_IDLE;
			code_q <= 16'h0000;
			last_target_q <= 16'h0000;
			start_q <= 16'h0000;
		end else begin
			last_target_q <= target;
			if (!slew_enable) begin
				// no stepping; an aborted slew lands on its target at once
				code_q <= target; // see (RULE10) (RULE16)
				state_q <= SLEW_IDLE;
			end else if (retarget) begin
				// new data or clear change: restart from the present code
				start_q <= code_q; // see (RULE13) (RULE12) (RULE22)
				state_q <= SLEW_RUN;
			end else if (state_q == SLEW_RUN && tick) begin
				code_q <= next_code; // see (RULE11)
				if (next_code == target) begin
					state_q <= SLEW_IDLE;
				end
			end else if (state_q == SLEW_IDLE && code_q != target) begin
				start_q <= code_q;
				state_q <= SLEW_RUN;
			end
		end
	end

	// ---- range and clear state outputs ----
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			range_q <= 1'b0;
			clear_q <= 1'b0;
		end else begin
			range_q <= clear_active ? fallback_span_select : span_select; // see (RULE2) (RULE17)
			clear_q <= clear_active;
		end
	end

	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	assign HRDATA_O = rdata_q;
	assign DAC_CODE_O = code_q; // see (RULE1)
	assign RANGE_SEL_O = range_q;
	assign CLEAR_STATE_O = clear_q;
	assign SLEWING_O = state_q == SLEW_RUN;

endmodule // dac_code_path_slew_clear

// ==== dac_code_pkg.sv ====
// constants, register map and types for the converter code path
package dac_code_pkg;
	localparam int CODE_W = 16;
	localparam int FAULT_W = 8;
	localparam logic [7:0] DATA_OFS = 8'h00;
	localparam logic [7:0] GAIN_OFS = 8'h04;
	localparam logic [7:0] OFFSET_OFS = 8'h08;
	localparam logic [7:0] CLR_CODE_OFS = 8'h0C;
	localparam logic [7:0] CFG_OFS = 8'h10;
	localparam logic [7:0] FAULT_RESP_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [15:0] GAIN_RST = 16'h8000;
	localparam logic [15:0] OFFSET_RST = 16'h0000;
	localparam logic [15:0] CLR_CODE_RST = 16'h0000;
	localparam logic [10:0] CFG_RST = 11'h000;
	localparam logic [15:0] FAULT_RESP_RST = 16'h0000;
	localparam logic [15:0] FULL_RES_MASK = 16'hFFFF;
	localparam logic [15:0] LOW_RES_MASK = 16'hFFFC;
	localparam logic [16:0] GAIN_HALF = 17'h08000;
	localparam logic [18:0] CODE_MAX = 19'h0FFFF;
	localparam int CFG_SLEW_EN = 0;
	localparam int CFG_STEP_LO = 1;
	localparam int CFG_RATE_LO = 4;
	localparam int CFG_PROFILE = 7;
	localparam int CFG_RANGE = 8;
	localparam int CFG_FB_SPAN = 9;
	localparam int CFG_FORCE_FB = 10;
	localparam int RESP_ACT_LO = 0;
	localparam int RESP_MASK_LO = 8;
	localparam int SUPPLY_FAULT_BIT = 0;
	localparam int STAT_CLEAR_BIT = 16;
	localparam int STAT_SLEW_BIT = 17;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SIN_EDGE_SHIFT = 2;
	localparam int SIN_BOOST_SHIFT = 2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [15:0] SLEW_STEP_LSB [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
		16'h0010, 16'h0020, 16'h0040, 16'h0080};
	localparam int SLEW_PERIOD_NS [8] = '{500, 1000, 2000, 4000, 8000, 16000, 32000, 64000};
	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_CLEAR = 2'b01,
		ACT_HOLD = 2'b10,
		ACT_RSVD = 2'b11
	} fault_act_e;
	typedef enum logic {
		SLEW_IDLE = 1'b0,
		SLEW_RUN = 1'b1
	} slew_state_e;
endpackage

// ==== dac_code_chk.sv ====
// port assertions for the converter code path
module dac_code_chk
	import dac_code_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic HREADY_I,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	input wire logic [31:0] HRDATA_O,
	input wire logic FALLBACK_INPUT_PIN_I,
	input wire logic BREAK_SDI_I,
	input wire logic BREAK_MODE_LINK_I,
	input wire logic [CODE_W-1:0] DAC_CODE_O,
	input wire logic CLEAR_STATE_O,
	input wire logic SLEWING_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	wire rd_take = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
	a_ready_high: assert property (HREADYOUT_O) else $error("hreadyout low");
	a_resp_okay: assert property (!HRESP_O) else $error("error response");
	a_reset_zero: assert property ($rose(RST_N_I) |-> DAC_CODE_O == 16'h0000 && !SLEWING_O)
		else $error("code or slew not idle after reset");
	a_pin_clear: assert property (!BREAK_MODE_LINK_I && FALLBACK_INPUT_PIN_I |=> CLEAR_STATE_O)
		else $error("clear pin ignored");
	a_sdi_clear: assert property (BREAK_MODE_LINK_I && BREAK_SDI_I |=> CLEAR_STATE_O)
		else $error("break mode clear ignored");
	// steps are at least 25 cycles apart, so two changes in a row mean a broken rate
	a_step_spacing: assert property (SLEWING_O && $changed(DAC_CODE_O) ##1 SLEWING_O |-> $stable(DAC_CODE_O))
		else $error("slew steps too close");
	a_unmapped_zero: assert property (rd_take && HADDR_I[31:8] != 24'h000000 |=> HRDATA_O == 32'h00000000)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!rd_take |=> $stable(HRDATA_O)) else $error("read data moved");
	cover property ($rose(SLEWING_O));
	cover property ($rose(CLEAR_STATE_O));
	cover property (rd_take && HADDR_I[31:8] != 24'h000000);
endmodule // dac_code_chk

// ==== tb.sv ====
// self-checking testbench for the converter code path
module tb
	import dac_code_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, pin = 1'b0, sdi = 1'b0, brk = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata;
	logic [7:0] faults = 8'h00;
	logic hready, hresp, clr, slewing, rng;
	logic [15:0] code;
	int fails = 0, cmp_count = 0;
	always #10 clk = ~clk;
	dac_code_path_slew_clear dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata), .FALLBACK_INPUT_PIN_I(pin),
		.BREAK_SDI_I(sdi), .BREAK_MODE_LINK_I(brk), .FAULT_EVENTS_I(faults), .DAC_CODE_O(code),
		.RANGE_SEL_O(rng), .CLEAR_STATE_O(clr), .SLEWING_O(slewing));
	task automatic close_out;
		if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				close_out();
			end
			@(posedge clk);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, {24'h000000, a}, d, r);
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h00000000, r);
		chk(r, exp);
	endtask
	task automatic wait_code(input logic [15:0] exp, input int lim);
		int n;
		n = 0;
		while (code !== exp && n < lim) begin
			tick(1);
			n++;
		end
		chk(code, exp);
	endtask
	task automatic t_reset;
		chk(code, 16'h0000);
		rd_chk({24'h000000, GAIN_OFS}, 32'h00008000);
		rd_chk({24'h000000, CFG_OFS}, 32'h00000000);
		rd_chk(32'h00000100, 32'h00000000);
	endtask
	task automatic t_cal;
		wr(DATA_OFS, 32'h4000);
		tick(3);
		chk(code, 16'h4000);
		wr(GAIN_OFS, 32'hFFFF);
		wr(OFFSET_OFS, 32'hFFFE);
		tick(3);
		chk(code, 16'h4000);
		wr(DATA_OFS, 32'h8000);
		tick(3);
		chk(code, 16'hBFFD);
		wr(OFFSET_OFS, 32'h8000);
		wr(DATA_OFS, 32'h0000);
		tick(3);
		chk(code, 16'h0000);
		wr(OFFSET_OFS, 32'h7FFF);
		wr(DATA_OFS, 32'hFFFF);
		tick(3);
		chk(code, 16'hFFFF);
		wr(GAIN_OFS, 32'h8000);
		wr(OFFSET_OFS, 32'h0000);
		wr(DATA_OFS, 32'h1000);
		tick(3);
		chk(code, 16'h1000);
	endtask
	// sources: pin, break sdi, fault, command, pin in break mode, masked fault
	task automatic t_clear;
		wr(CLR_CODE_OFS, 32'h0123);
		wr(FAULT_RESP_OFS, 32'h0001);
		wr(CFG_OFS, 32'h0200);
		for (int s = 0; s < 6; s++) begin
			if (s == 5) wr(FAULT_RESP_OFS, 32'h0101);
			pin <= (s == 0 || s == 4);
			brk <= (s == 1 || s == 4);
			sdi <= (s == 1);
			faults <= {7'h00, s == 2 || s == 5};
			if (s == 3) wr(CFG_OFS, 32'h0600);
			tick(2);
			chk(clr, s < 4);
			chk(rng, s < 4);
			chk(code, (s < 4) ? 16'h0123 : 16'h1000);
			pin <= 1'b0;
			brk <= 1'b0;
			sdi <= 1'b0;
			faults <= 8'h00;
			if (s == 3) wr(CFG_OFS, 32'h0200);
			tick(3);
			chk(code, 16'h1000);
			chk(rng, 1'b0);
		end
	endtask
	task automatic t_slew;
		wr(CFG_OFS, 32'h0007);
		wr(DATA_OFS, 32'h1040);
		tick(30);
		chk(slewing, 1'b1);
		chk(code > 16'h1000 && code < 16'h1040 && code[2:0] == 3'h0, 1'b1);
		wait_code(16'h1040, 400);
		wr(DATA_OFS, 32'h2000);
		tick(60);
		wr(CFG_OFS, 32'h0006);
		tick(2);
		chk(code, 16'h2000);
		wr(CFG_OFS, 32'h0087);
		wr(DATA_OFS, 32'h2100);
		wait_code(16'h2100, 2000);
		wr(CLR_CODE_OFS, 32'h20C0);
		pin <= 1'b1;
		tick(30);
		chk(slewing, 1'b1);
		wait_code(16'h20C0, 400);
		pin <= 1'b0;
		wait_code(16'h2100, 400);
		rd_chk({24'h000000, STATUS_OFS}, 32'h00002100);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		t_reset();
		t_cal();
		t_clear();
		t_slew();
		close_out();
	end
endmodule // tb
bind dac_code_path_slew_clear dac_code_chk chk_i (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
	.HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
	.HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .HRDATA_O(HRDATA_O),
	.FALLBACK_INPUT_PIN_I(FALLBACK_INPUT_PIN_I), .BREAK_SDI_I(BREAK_SDI_I),
	.BREAK_MODE_LINK_I(BREAK_MODE_LINK_I), .DAC_CODE_O(DAC_CODE_O),
	.CLEAR_STATE_O(CLEAR_STATE_O), .SLEWING_O(SLEWING_O));
